/* rtl/ssq_status_query.sv */
// Status query command interpreter with an APB register interface.
// Assumes status flags and values come from controller logic on pclk, needing no synchroniser.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ssq_consts.svh"

// Behaviour
// - Trace word is 16 bits: servo, move, in-position, program, tuning, jogging.
// - Trace bits 6 to 10: homing, feeding, trace mode, fault, LCD prompt.
// - Commanded speed reply: prefix, then eight hex digits of counts per second.
// - Peak speed reply: prefix, then eight hex digits of highest reached speed.
// - Unit reply carries a four digit unit code; zero means inches.
// - Actual speed reply: eight hex digits of measured speed.
// - Velocity gain reply: prefix, then four hex digits of the gain.
// - Repeatability reply gives measured repeatability in encoder counts.
// - Pause word bits 6 to 0 hold input selection; bits 15 to 7 zero.
// - Pause word bits 19 to 16 hold input type; bits 27 to 20 zero.
// - Pause word bits 31 to 28 report pause cause.
// - Firmware query answers with a text message naming product and version.
// - Valve command flag one energizes both coils while in position.
// - Jog flag zero jogs backward, one jogs forward.
module ssq_status_query (
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller state on the same clock.
   input wire ssq_pkg::ssq_flags_s flags,
   input wire ssq_pkg::ssq_values_s vals,
   // Actuator controls and interrupt.
   output logic jog_fwd,
   output logic jog_bwd,
   output logic valve_energize,
   output logic irq
);

   ssq_pkg::ssq_reply_s rep;
   logic rep_busy;
   logic [3:0] ch_idx;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [2:0] next_irq_stat;
   logic [2:0] next_irq_mask;
   logic [7:0] cur_ch;
   logic ch_last;
   logic jog_end;
   logic jog_refused;

   // Builds the reply for a query command; non-queries come back with ok low.
   function automatic ssq_pkg::ssq_reply_s build_reply(
      input ssq_pkg::ssq_cmd_e code,
      input ssq_pkg::ssq_flags_s f,
      input ssq_pkg::ssq_values_s v,
      input logic jogging
   );
      ssq_pkg::ssq_reply_s r;
      r = '0;
      r.ok = 1'b1;
      r.ndig = `SSQ_DIG_HALF;
      case (code)
         ssq_pkg::ssq_c_trace: begin
            r.prefix = `SSQ_PFX_TRACE;
            r.word = {16'h0000, 5'h00, f.lcd_pending, f.fault, f.trace_on, f.feeding,
                      f.homing, jogging, f.tuning, f.prog_run, f.in_pos, f.move_active,
                      f.servo_run};
         end
         ssq_pkg::ssq_c_cspd: begin
            r.prefix = `SSQ_PFX_CSPD;
            r.ndig = `SSQ_DIG_WORD;
            r.word = v.cmd_speed;
         end
         ssq_pkg::ssq_c_peak: begin
            r.prefix = `SSQ_PFX_PEAK;
            r.ndig = `SSQ_DIG_WORD;
            r.word = v.peak_speed;
         end
         ssq_pkg::ssq_c_torq: begin
            r.prefix = `SSQ_PFX_TORQ;
            r.word = {16'h0000, v.torque};
         end
         ssq_pkg::ssq_c_unit: begin
            r.prefix = `SSQ_PFX_UNIT;
            r.word = {16'h0000, v.unit};
         end
         ssq_pkg::ssq_c_aspd: begin
            r.prefix = `SSQ_PFX_ASPD;
            r.ndig = `SSQ_DIG_WORD;
            r.word = v.act_speed;
         end
         ssq_pkg::ssq_c_gain: begin
            r.prefix = `SSQ_PFX_GAIN;
            r.word = {16'h0000, v.gain};
         end
         ssq_pkg::ssq_c_rept: begin
            r.prefix = `SSQ_PFX_REPT;
            r.word = {16'h0000, v.repeatab};
         end
         ssq_pkg::ssq_c_pause: begin
            r.prefix = `SSQ_PFX_PAUSE;
            r.ndig = `SSQ_DIG_WORD;
            r.word = {v.pause_state, 8'h00, v.pause_type, 9'h000, v.pause_sel};
         end
         ssq_pkg::ssq_c_fw: begin
            r.text = 1'b1;
            r.ndig = 4'h0;
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   // APB phases: access waits one cycle, the transfer completes when pready is seen.
   wire logic acc = psel & penable & ~pready;
   wire logic done = psel & penable & pready;

   // Address decode.
   wire logic hit_cmd = (paddr == `SSQ_OFF_CMD);
   wire logic hit_word = (paddr == `SSQ_OFF_WORD);
   wire logic hit_char = (paddr == `SSQ_OFF_CHAR);
   wire logic hit_istat = (paddr == `SSQ_OFF_ISTAT);
   wire logic hit_imask = (paddr == `SSQ_OFF_IMASK);
   wire logic hit_ctrl = (paddr == `SSQ_OFF_CTRL);
   wire logic mapped = hit_cmd | hit_word | hit_char | hit_istat | hit_imask | hit_ctrl;

   // Command decode at the completing edge of a command write.
   wire ssq_pkg::ssq_cmd_e cmd_code = ssq_pkg::ssq_cmd_e'(pwdata[7:0]);
   wire logic cmd_flag = pwdata[`SSQ_CMD_FLAG_BIT];
   wire logic wr_cmd = done & pwrite & hit_cmd;
   wire logic jogging = jog_fwd | jog_bwd;
   wire ssq_pkg::ssq_reply_s next_rep = build_reply(cmd_code, flags, vals, jogging);
   wire logic is_valve = (cmd_code == ssq_pkg::ssq_c_valve);
   wire logic is_jog = (cmd_code == ssq_pkg::ssq_c_jog);
   wire logic is_stop = (cmd_code == ssq_pkg::ssq_c_stop);
   wire logic is_set = is_valve | is_jog | is_stop;

   // Reads that have side effects, and the mask write.
   wire logic rd_istat = done & ~pwrite & hit_istat;
   wire logic pop = done & ~pwrite & hit_char & rep_busy;
   wire logic wr_imask = done & pwrite & hit_imask;

   // Events into the sticky status.
   wire logic ev_reply = wr_cmd & next_rep.ok;
   wire logic ev_refuse = (wr_cmd & ~next_rep.ok & ~is_set) | jog_refused;
   wire logic [2:0] events = {ev_refuse, jog_end, ev_reply};

   // Read data selection; unused upper bits read as zero.
   wire logic [31:0] rd_mux =
      hit_word ? (rep_busy ? rep.word : 32'h0000_0000) :
      hit_char ? {23'h00_0000, rep_busy, rep_busy ? cur_ch : 8'h00} :
      hit_istat ? {29'h0000_0000, irq_stat} :
      hit_imask ? {29'h0000_0000, irq_mask} :
      hit_ctrl ? {29'h0000_0000, jog_fwd, jogging, valve_energize} :
      32'h0000_0000;

   // Sticky status; a read clears only the bits it returned, so an event that lands after
   // the read data was captured is not lost. A same-cycle event wins over the clear.
   assign next_irq_stat = (rd_istat ? (irq_stat & ~prdata[2:0]) : irq_stat) | events;
   assign next_irq_mask = wr_imask ? pwdata[2:0] : irq_mask;

   // Reply character generator.
   ssq_reply_fmt u_fmt (
      .rep(rep),
      .idx(ch_idx),
      .ch(cur_ch),
      .last(ch_last)
   );

   // Jog sequencer; the stop command ends a jog.
   ssq_jog_ctl u_jog (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .jog_req(wr_cmd & is_jog),
      .jog_flag(cmd_flag),
      .stop_req(wr_cmd & is_stop),
      .servo_run(flags.servo_run),
      .jog_fwd(jog_fwd),
      .jog_bwd(jog_bwd),
      .jog_end(jog_end),
      .refused(jog_refused)
   );

   // APB answer: one wait state, data and error prepared in the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= acc;
         prdata <= acc && !pwrite ? rd_mux : 32'h0000_0000;
         pslverr <= acc & ~mapped;
      end
   end

   // Reply capture and character stream.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep <= '0;
         rep_busy <= 1'b0;
         ch_idx <= 4'h0;
      end else if (ce) begin
         if (ev_reply) begin
            rep <= next_rep;
            rep_busy <= 1'b1;
            ch_idx <= 4'h0;
         end else if (pop) begin
            rep_busy <= !ch_last;
            ch_idx <= 4'(ch_idx + 4'h1);
         end
      end
   end

   // Valve hold setting, interrupt status, mask and line.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valve_energize <= `SSQ_VALVE_RST;
         irq_stat <= 3'h0;
         irq_mask <= `SSQ_IMASK_RST;
         irq <= 1'b0;
      end else if (ce) begin
         if (wr_cmd && is_valve) begin
            valve_energize <= cmd_flag;
         end
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq <= |(next_irq_stat & next_irq_mask);
      end
   end

   // Helper: a command write of any code is being taken this cycle.
   wire logic take = ce & wr_cmd;

   property p_trace_lo;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_trace) |=> rep_busy && rep.ndig == 4'h4 &&
         rep.word[4:0] == $past({flags.tuning, flags.prog_run, flags.in_pos,
                                 flags.move_active, flags.servo_run}) &&
         rep.word[5] == $past(jogging);
   endproperty
   a_trace_lo: assert property (p_trace_lo) else $error("trace low bits wrong");

   property p_trace_hi;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_trace) |=>
         rep.word[10:6] == $past({flags.lcd_pending, flags.fault, flags.trace_on,
                                  flags.feeding, flags.homing});
   endproperty
   a_trace_hi: assert property (p_trace_hi) else $error("trace high bits wrong");

   property p_cspd;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_cspd) |=>
         rep.word == $past(vals.cmd_speed) && rep.ndig == 4'h8 && rep.prefix == 16'h4353;
   endproperty
   a_cspd: assert property (p_cspd) else $error("commanded speed reply wrong");

   property p_peak;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_peak) |=>
         rep.word == $past(vals.peak_speed) && rep.ndig == 4'h8;
   endproperty
   a_peak: assert property (p_peak) else $error("peak speed reply wrong");

   property p_half;
      @(posedge pclk) disable iff (!presetn)
      (take && (cmd_code == ssq_pkg::ssq_c_torq || cmd_code == ssq_pkg::ssq_c_unit ||
                cmd_code == ssq_pkg::ssq_c_gain || cmd_code == ssq_pkg::ssq_c_rept))
         |=> rep.ndig == 4'h4 && rep.word[31:16] == 16'h0000 && rep_busy;
   endproperty
   a_half: assert property (p_half) else $error("short reply wrong");

   property p_aspd;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_aspd) |=>
         rep.word == $past(vals.act_speed) && rep.ndig == 4'h8;
   endproperty
   a_aspd: assert property (p_aspd) else $error("actual speed reply wrong");

   property p_pause;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_pause) |=>
         rep.word[6:0] == $past(vals.pause_sel) && rep.word[15:7] == 9'h000 &&
         rep.word[19:16] == $past(vals.pause_type) && rep.word[27:20] == 8'h00 &&
         rep.word[31:28] == $past(vals.pause_state);
   endproperty
   a_pause: assert property (p_pause) else $error("pause word wrong");

   property p_fw;
      @(posedge pclk) disable iff (!presetn)
      (take && cmd_code == ssq_pkg::ssq_c_fw) |=> rep_busy && rep.text;
   endproperty
   a_fw: assert property (p_fw) else $error("firmware reply not text");

   property p_valve;
      @(posedge pclk) disable iff (!presetn)
      (take && is_valve) |=> valve_energize == $past(cmd_flag);
   endproperty
   a_valve: assert property (p_valve) else $error("valve flag not taken");

   property p_resv;
      @(posedge pclk) disable iff (!presetn)
      (rep_busy && !rep.text && rep.ndig == 4'h4) |-> rep.word[31:16] == 16'h0000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved reply bits set");

endmodule // ssq_status_query

/* inc/ssq_consts.svh */
// Register offsets, field positions, reset values and reply prefixes of the status query block.
// Assumes a 12-bit APB byte address with one aligned 32-bit word per register.
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH

// Register byte offsets.
`define SSQ_OFF_CMD 12'h000
`define SSQ_OFF_WORD 12'h004
`define SSQ_OFF_CHAR 12'h008
`define SSQ_OFF_ISTAT 12'h00C
`define SSQ_OFF_IMASK 12'h010
`define SSQ_OFF_CTRL 12'h014

// Field positions.
`define SSQ_CMD_FLAG_BIT 8
`define SSQ_IRQ_REPLY 0
`define SSQ_IRQ_JOGEND 1
`define SSQ_IRQ_REFUSE 2

// Reset values.
`define SSQ_IMASK_RST 3'h0
`define SSQ_VALVE_RST 1'b0

// Reply prefixes as two ASCII characters, and the separator.
`define SSQ_PFX_TRACE 16'h4353
`define SSQ_PFX_CSPD 16'h4353
`define SSQ_PFX_PEAK 16'h4D53
`define SSQ_PFX_TORQ 16'h4254
`define SSQ_PFX_UNIT 16'h5555
`define SSQ_PFX_ASPD 16'h5350
`define SSQ_PFX_GAIN 16'h4B56
`define SSQ_PFX_REPT 16'h5250
`define SSQ_PFX_PAUSE 16'h5049
`define SSQ_ASCII_EQ 8'h3D

// Reply lengths in characters or digits.
`define SSQ_DIG_WORD 4'h8
`define SSQ_DIG_HALF 4'h4
`define SSQ_FW_LEN 4'hA
`define SSQ_HDR_LEN 4'h3

`endif

/* inc/ssq_pkg.sv */
// Types shared by the status query block: commands, status carriers and reply descriptor.
// Assumes nothing of its surroundings.
package ssq_pkg;

   // Command codes written to the command register.
   typedef enum logic [7:0] {
      ssq_c_none = 8'h00,
      ssq_c_trace = 8'h01,
      ssq_c_cspd = 8'h02,
      ssq_c_peak = 8'h03,
      ssq_c_torq = 8'h04,
      ssq_c_unit = 8'h05,
      ssq_c_aspd = 8'h06,
      ssq_c_gain = 8'h07,
      ssq_c_rept = 8'h08,
      ssq_c_pause = 8'h09,
      ssq_c_fw = 8'h0A,
      ssq_c_valve = 8'h10,
      ssq_c_jog = 8'h11,
      ssq_c_stop = 8'h12
   } ssq_cmd_e;

   // Input type codes of the pause word.
   typedef enum logic [3:0] {
      ssq_pt_single_lo = 4'h0,
      ssq_pt_single_hi = 4'h1,
      ssq_pt_multi_byte = 4'h8,
      ssq_pt_multi_all_lo = 4'hA,
      ssq_pt_multi_all_hi = 4'hC
   } ssq_ptype_e;

   // Jog sequencer states, Gray coded along idle, run, stop.
   typedef enum logic [1:0] {
      ssq_jog_idle = 2'b00,
      ssq_jog_run = 2'b01,
      ssq_jog_stop = 2'b11
   } ssq_jog_e;

   // Controller status flags.
   typedef struct packed {
      logic lcd_pending;
      logic fault;
      logic trace_on;
      logic feeding;
      logic homing;
      logic tuning;
      logic prog_run;
      logic in_pos;
      logic move_active;
      logic servo_run;
   } ssq_flags_s;

   // Controller values that the queries report.
   typedef struct packed {
      logic [31:0] cmd_speed;
      logic [31:0] peak_speed;
      logic [31:0] act_speed;
      logic [15:0] torque;
      logic [15:0] unit;
      logic [15:0] gain;
      logic [15:0] repeatab;
      logic [3:0] pause_state;
      ssq_ptype_e pause_type;
      logic [6:0] pause_sel;
   } ssq_values_s;

   // Reply descriptor: text message or prefix, separator and hex digits.
   typedef struct packed {
      logic ok;
      logic text;
      logic [15:0] prefix;
      logic [3:0] ndig;
      logic [31:0] word;
   } ssq_reply_s;

endpackage

/* rtl/ssq_reply_fmt.sv */
// Reply character generator: picks the ASCII character at a given index of a reply.
// Assumes the caller holds the descriptor and the index stable while it reads the character.
`timescale 1ns/10ps
`include "ssq_consts.svh"

module ssq_reply_fmt #(
   // Firmware message, ten characters; the value is arbitrary.
   parameter logic [79:0] FW_MSG = 80'h4354_524C_2056_302E_3031
) (
   // Reply and position.
   input wire ssq_pkg::ssq_reply_s rep,
   input wire logic [3:0] idx,
   // Character out.
   output logic [7:0] ch,
   output logic last
);

   // Converts one nibble into its upper-case hex digit.
   function automatic logic [7:0] hex_ascii(input logic [3:0] n);
      hex_ascii = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Digit position counted from the least significant nibble.
   wire logic [3:0] pos = 4'(rep.ndig + `SSQ_HDR_LEN - 4'h1 - idx);
   wire logic [3:0] nib = 4'(rep.word >> {pos, 2'b00});
   wire logic [7:0] txt = 8'(FW_MSG >> {4'(`SSQ_FW_LEN - 4'h1 - idx), 3'b000});
   wire logic [3:0] len = rep.text ? `SSQ_FW_LEN : 4'(`SSQ_HDR_LEN + rep.ndig);

   // Prefix, separator, then digits from the most significant down.
   assign ch = rep.text ? txt :
               (idx == 4'h0) ? rep.prefix[15:8] :
               (idx == 4'h1) ? rep.prefix[7:0] :
               (idx == 4'h2) ? `SSQ_ASCII_EQ : hex_ascii(nib);
   assign last = (idx == 4'(len - 4'h1));

endmodule // ssq_reply_fmt

/* rtl/ssq_jog_ctl.sv */
// Jog sequencer: starts a jog in the flagged direction and holds it until a stop command.
// Assumes one-cycle command pulses from the interpreter on the same clock.
`timescale 1ns/10ps

module ssq_jog_ctl (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Commands.
   input wire logic jog_req,
   input wire logic jog_flag,
   input wire logic stop_req,
   input wire logic servo_run,
   // Drive and events.
   output logic jog_fwd,
   output logic jog_bwd,
   output logic jog_end,
   output logic refused
);

   ssq_pkg::ssq_jog_e state;
   ssq_pkg::ssq_jog_e next_state;
   logic dir;
   logic next_dir;

   // Next state: a jog needs a running servo loop and lasts until stopped.
   always_comb begin
      next_state = state;
      next_dir = dir;
      case (state)
         ssq_pkg::ssq_jog_idle: begin
            if (jog_req && servo_run) begin
               next_state = ssq_pkg::ssq_jog_run;
               next_dir = jog_flag;
            end
         end
         ssq_pkg::ssq_jog_run: begin
            if (stop_req) begin
               next_state = ssq_pkg::ssq_jog_stop;
            end else if (jog_req) begin
               next_dir = jog_flag;
            end
         end
         ssq_pkg::ssq_jog_stop: next_state = ssq_pkg::ssq_jog_idle;
         default: next_state = ssq_pkg::ssq_jog_idle;
      endcase
   end

   // State and registered drive; a one flag jogs forward, zero backward.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ssq_pkg::ssq_jog_idle;
         dir <= 1'b0;
         jog_fwd <= 1'b0;
         jog_bwd <= 1'b0;
         jog_end <= 1'b0;
         refused <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         dir <= next_dir;
         jog_fwd <= (next_state == ssq_pkg::ssq_jog_run) && next_dir;
         jog_bwd <= (next_state == ssq_pkg::ssq_jog_run) && !next_dir;
         jog_end <= (next_state == ssq_pkg::ssq_jog_stop);
         refused <= jog_req && !servo_run && (state != ssq_pkg::ssq_jog_run);
      end
   end

   // A forward flag drives the forward output only.
   property p_jog_dir;
      @(posedge pclk) disable iff (!presetn)
      (ce && jog_req && servo_run && !stop_req && state != ssq_pkg::ssq_jog_stop)
         |=> (jog_fwd == $past(jog_flag)) && (jog_bwd == !$past(jog_flag));
   endproperty
   a_jog_dir: assert property (p_jog_dir) else $error("jog direction wrong");

   // A running jog keeps going while no stop arrives.
   property p_jog_hold;
      @(posedge pclk) disable iff (!presetn)
      ((jog_fwd || jog_bwd) && !stop_req) |=> (jog_fwd || jog_bwd);
   endproperty
   a_jog_hold: assert property (p_jog_hold) else $error("jog ended without stop");

endmodule // ssq_jog_ctl

/* verification/ssq_host_model.sv */
// Host terminal model: an APB master that writes commands and reads replies.
// Assumes a slave on the same pclk that ends each transfer with pready.
`timescale 1ns/10ps

module ssq_host_model (
   // Clock.
   input wire logic pclk,
   // APB master side.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // The bus idles from time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end

   // One transfer, held until pready is seen at a rising edge; a hang returns an unknown error.
   // Data and error are taken at that same edge, and only then is the request released.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      r = 32'h0;
      e = 1'bx;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            r = prdata;
            e = pslverr;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // ssq_host_model

/* verification/ssq_status_query_bench.sv */
// Bench of the status query block: random controller state, replies, valve, jog, interrupt.
// Assumes the host model drives APB and the bench drives controller state on pclk.
`timescale 1ns/10ps
`include "ssq_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module ssq_status_query_bench;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
   logic jog_fwd, jog_bwd, valve_energize, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   ssq_pkg::ssq_flags_s flags;
   ssq_pkg::ssq_values_s vals;
   int fail_count, total_checks;

   // Free-running 250 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   ssq_status_query ssq_status_query_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flags(flags), .vals(vals), .jog_fwd(jog_fwd),
      .jog_bwd(jog_bwd), .valve_energize(valve_energize), .irq(irq));
   ssq_host_model ssq_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Expected reply word of a query code, from the state the bench handed in.
   function automatic logic [31:0] exp_word(input logic [7:0] c);
      case (c)
         8'h01: return {16'h0, 5'h0, flags[9:5], 1'b0, flags[4:0]};
         8'h02: return vals.cmd_speed;
         8'h03: return vals.peak_speed;
         8'h04: return {16'h0, vals.torque};
         8'h05: return {16'h0, vals.unit};
         8'h06: return vals.act_speed;
         8'h07: return {16'h0, vals.gain};
         8'h08: return {16'h0, vals.repeatab};
         default: return {vals.pause_state, 8'h0, vals.pause_type, 9'h0, vals.pause_sel};
      endcase
   endfunction

   // ASCII of one upper-case hex digit.
   function automatic logic [7:0] hex(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // One bus transfer; a hung transfer counts as a mismatch and ends the run.
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      ssq_host_model_i.xfer(w, a, d, rdat, rerr);
      if (rerr === 1'bx) begin
         fail_count++;
         stop_test();
      end
   endtask

   // Reads a reply as characters: prefix, separator, n hex digits MSB first, then none left.
   task automatic chars(input logic [15:0] p, input int n, input logic [31:0] w);
      logic [7:0] x;
      for (int j = 0; j < n + 3; j++) begin
         x = (j == 0) ? p[15:8] : (j == 1) ? p[7:0] : (j == 2) ? 8'h3D : hex(w[4*(n+2-j)+3 -: 4]);
         acc(1'b0, `SSQ_OFF_CHAR, 32'h0);
         `CHK(rdat, {23'h0, 1'b1, x})
      end
      acc(1'b0, `SSQ_OFF_CHAR, 32'h0);
      `CHK(rdat[8], 1'b0)
   endtask

   // Reset, random queries, firmware text, interrupt mask, valve, jog and faults.
   initial begin
      logic [191:0] rnd;
      ssq_pkg::ssq_values_s v;
      logic [3:0] pt[5] = '{4'h0, 4'h1, 4'h8, 4'hA, 4'hC};
      fail_count = 0;
      total_checks = 0;
      presetn = 1'b0;
      ce = 1'b1;
      flags = '0;
      vals = '0;
      rdat = $urandom(32'h3811);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK({irq, jog_fwd, jog_bwd, valve_energize}, 4'h0)
      acc(1'b1, `SSQ_OFF_IMASK, 32'h7);
      for (int k = 0; k < 5; k++) begin
         rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
         v = rnd[174:0];
         v.pause_type = ssq_pkg::ssq_ptype_e'(pt[k]);
         v.pause_state = k[3:0];
         if (k == 0) v.unit = 16'h0;
         @(posedge pclk);
         vals <= v;
         flags <= ssq_pkg::ssq_flags_s'(rnd[191:182]);
         for (int c = 1; c < 10; c++) begin
            acc(1'b1, `SSQ_OFF_CMD, 32'(c));
            @(negedge pclk);
            `CHK(irq, 1'b1)
            acc(1'b0, `SSQ_OFF_WORD, 32'h0);
            `CHK(rdat, exp_word(c[7:0]))
            if (c == 2) chars(`SSQ_PFX_CSPD, 8, vals.cmd_speed);
            if (c == 7) chars(`SSQ_PFX_GAIN, 4, {16'h0, vals.gain});
            acc(1'b0, `SSQ_OFF_ISTAT, 32'h0);
            `CHK(rdat, 32'h1)
         end
      end
      acc(1'b1, `SSQ_OFF_CMD, 32'hA);
      for (int j = 0; j < 11; j++) begin
         acc(1'b0, `SSQ_OFF_CHAR, 32'h0);
         `CHK(rdat[8], (j < 10))
      end
      // A pending reply raises the interrupt only while unmasked; reading status clears it.
      acc(1'b1, `SSQ_OFF_IMASK, 32'h0);
      @(negedge pclk);
      `CHK(irq, 1'b0)
      acc(1'b1, `SSQ_OFF_IMASK, 32'h7);
      acc(1'b0, `SSQ_OFF_ISTAT, 32'h0);
      @(negedge pclk);
      `CHK({irq, rdat[0]}, 2'b01)
      for (int f = 1; f >= 0; f--) begin
         acc(1'b1, `SSQ_OFF_CMD, {23'h0, f[0], 8'h10});
         @(negedge pclk);
         `CHK(valve_energize, f[0])
      end
      @(posedge pclk);
      flags <= '0;
      acc(1'b1, `SSQ_OFF_CMD, {23'h0, 1'b1, 8'h11});
      acc(1'b0, `SSQ_OFF_ISTAT, 32'h0);
      `CHK({rdat[2], jog_fwd}, 2'b10)
      flags <= ssq_pkg::ssq_flags_s'(10'h1);
      for (int f = 1; f >= 0; f--) begin
         acc(1'b1, `SSQ_OFF_CMD, {23'h0, f[0], 8'h11});
         @(negedge pclk);
         `CHK({jog_fwd, jog_bwd}, {f[0], ~f[0]})
      end
      acc(1'b1, `SSQ_OFF_CMD, 32'h1);
      acc(1'b0, `SSQ_OFF_WORD, 32'h0);
      `CHK(rdat[5], 1'b1)
      acc(1'b1, `SSQ_OFF_CMD, 32'h12);
      @(negedge pclk);
      `CHK({jog_fwd, jog_bwd}, 2'b00)
      acc(1'b0, `SSQ_OFF_ISTAT, 32'h0);
      `CHK(rdat[1], 1'b1)
      acc(1'b1, `SSQ_OFF_CMD, 32'h33);
      acc(1'b0, `SSQ_OFF_ISTAT, 32'h0);
      `CHK(rdat[2], 1'b1)
      acc(1'b0, 12'h040, 32'h0);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      stop_test();
   end
endmodule // ssq_status_query_bench
